// ==== core/pwe_pkg.sv ====
// Package: register map, field layout and reset values of the posted-write error bank
package pwe_pkg;
    localparam logic [7:0]  PWE_OFF_OFFS_LO  = 8'h38;
    localparam logic [7:0]  PWE_OFF_OFFS_HI  = 8'h3C;
    localparam logic [7:0]  PWE_OFF_ORG_ID   = 8'h40;
    localparam logic [7:0]  PWE_OFF_FLAG_SET = 8'h50;
    localparam logic [7:0]  PWE_OFF_FLAG_CLR = 8'h54;
    localparam int          PWE_BUS_MSB      = 31;
    localparam int          PWE_BUS_LSB      = 22;
    localparam int          PWE_NODE_MSB     = 21;
    localparam int          PWE_NODE_LSB     = 16;
    localparam int          PWE_OHI_MSB      = 15;
    // Arbitrary neutral identifier value
    localparam logic [31:0] PWE_ORG_ID_VAL   = 32'h00C0_FFEE;
    // Flag bit classes in the upper half
    localparam logic [31:0] PWE_FLAG_RSU     = 32'h8000_0000;
    localparam logic [31:0] PWE_FLAG_RSC     = 32'h6007_0000;
    localparam logic [31:0] PWE_FLAG_RC      = 32'h0000_0000;
    localparam logic [31:0] PWE_FLAG_RO      = 32'h0080_0000;
    localparam logic [31:0] PWE_FLAG_RST     = 32'h0080_0000;
    localparam logic [31:0] PWE_ZERO         = 32'h0000_0000;
    localparam int          PWE_LINK_EN_BIT  = 17;
    localparam int          PWE_BIB_BIT      = 31;
endpackage

// ==== core/pwe_capture_if.sv ====
// Interface: failure capture event from the link receive side
`timescale 1ns/10ps
interface pwe_capture_if;
    logic        fail_stb;
    logic [9:0]  bus_num;
    logic [5:0]  node_num;
    logic [47:0] dest_offset;
    modport src  (output fail_stb, output bus_num, output node_num, output dest_offset);
    modport sink (input fail_stb, input bus_num, input node_num, input dest_offset);
endinterface

// ==== core/pwe_capture.sv ====
// Capture store for a failed posted write
`timescale 1ns/10ps
module pwe_capture
    import pwe_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   srst,
    pwe_capture_if.sink cap,
    output logic [31:0] offs_lo_q,
    output logic [31:0] offs_hi_q
);
    typedef struct packed {
        logic [31:0] lo;
        logic [31:0] hi;
    } pwe_cap_t;
    pwe_cap_t s_q;
    pwe_cap_t s_d;

    always_comb begin
        s_d = s_q;
        if (cap.fail_stb) begin
            s_d.hi[PWE_BUS_MSB:PWE_BUS_LSB]   = cap.bus_num;
            s_d.hi[PWE_NODE_MSB:PWE_NODE_LSB] = cap.node_num;
            s_d.hi[PWE_OHI_MSB:0]             = cap.dest_offset[47:32];
            s_d.lo                            = cap.dest_offset[31:0];
        end
    end

    // Contents undefined until a failure; cleared only for clean simulation
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign offs_lo_q = s_q.lo;
    assign offs_hi_q = s_q.hi;

    a_capture_hi: assert property (@(posedge clk_sys) disable iff (srst)
        cap.fail_stb |=> offs_hi_q == {$past(cap.bus_num), $past(cap.node_num),
                                       $past(cap.dest_offset[47:32])})
        else $error("high capture wrong");
    a_capture_lo: assert property (@(posedge clk_sys) disable iff (srst)
        cap.fail_stb |=> offs_lo_q == $past(cap.dest_offset[31:0]))
        else $error("low capture wrong");
    a_capture_hold: assert property (@(posedge clk_sys) disable iff (srst)
        !cap.fail_stb |=> $stable(offs_hi_q) && $stable(offs_lo_q))
        else $error("capture changed without failure");
    c_capture: cover property (@(posedge clk_sys) disable iff (srst) cap.fail_stb);
endmodule

// ==== core/pwe_regs.sv ====
// Top: APB register bank for posted-write error capture and control flags
`timescale 1ns/10ps
module pwe_regs
    import pwe_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fail_stb,
    input  wire logic [9:0]  fail_bus_num,
    input  wire logic [5:0]  fail_node_num,
    input  wire logic [47:0] fail_dest_offset,
    input  wire logic        hw_flag_clr,
    output logic [31:0]      ctrl_flags
);
    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] rdata;
        logic        err;
    } pwe_state_t;
    pwe_state_t s_q;
    pwe_state_t s_d;

    logic [31:0] offs_lo_q;
    logic [31:0] offs_hi_q;
    logic        acc;
    logic [31:0] wmask;
    // Write strobes of the two flag addresses
    logic        set_wr;
    logic        clr_wr;

    pwe_capture_if cap_if ();
    assign cap_if.fail_stb    = fail_stb;
    assign cap_if.bus_num     = fail_bus_num;
    assign cap_if.node_num    = fail_node_num;
    assign cap_if.dest_offset = fail_dest_offset;

    pwe_capture pwe_capture_i (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .cap       (cap_if.sink),
        .offs_lo_q (offs_lo_q),
        .offs_hi_q (offs_hi_q)
    );

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // Read-only words: writes refused, contents untouched
    function automatic logic is_ro_word(input logic [7:0] a);
        return a == PWE_OFF_OFFS_LO || a == PWE_OFF_OFFS_HI || a == PWE_OFF_ORG_ID;
    endfunction

    // Both flag addresses act on one word
    function automatic logic is_flag_word(input logic [7:0] a);
        return a == PWE_OFF_FLAG_SET || a == PWE_OFF_FLAG_CLR;
    endfunction

    // Zero-wait slave: setup then one access cycle
    assign acc   = psel && penable;
    assign wmask = pwdata & strb_mask(pstrb);
    assign set_wr = acc && pwrite && paddr == PWE_OFF_FLAG_SET;
    assign clr_wr = acc && pwrite && paddr == PWE_OFF_FLAG_CLR;

    always_comb begin
        s_d = s_q;
        s_d.err = 1'b0;
        // Hardware clear of update bits, e.g. on a fetch error
        if (hw_flag_clr) begin
            s_d.flags = s_d.flags & ~PWE_FLAG_RSU;
        end
        if (psel && !penable) begin
            s_d.rdata = PWE_ZERO;
            unique case (paddr)
                PWE_OFF_OFFS_LO:  s_d.rdata = offs_lo_q;
                PWE_OFF_OFFS_HI:  s_d.rdata = offs_hi_q;
                PWE_OFF_ORG_ID:   s_d.rdata = PWE_ORG_ID_VAL;
                PWE_OFF_FLAG_SET,
                PWE_OFF_FLAG_CLR: s_d.rdata = s_q.flags;
                default:          s_d.err   = 1'b1;
            endcase
            // Read-only words refuse writes with an error, contents untouched
            if (pwrite && is_ro_word(paddr)) begin
                s_d.err = 1'b1;
            end
        end
        if (acc) begin
            s_d.err = s_q.err;
        end
        // Set applied after the hardware clear, so the set wins
        if (set_wr) begin
            // Update bit may be set only while the link is disabled
            if (!s_q.flags[PWE_LINK_EN_BIT]) begin
                s_d.flags = s_d.flags | (wmask & PWE_FLAG_RSU);
            end
            s_d.flags = s_d.flags | (wmask & PWE_FLAG_RSC);
        end
        if (clr_wr) begin
            s_d.flags = s_d.flags
                        & ~(wmask & (PWE_FLAG_RSU | PWE_FLAG_RSC | PWE_FLAG_RC));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q.flags <= PWE_FLAG_RST;
            s_q.rdata <= PWE_ZERO;
            s_q.err   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata     = s_q.rdata;
    assign pready     = acc;
    assign pslverr    = acc && s_q.err;
    assign ctrl_flags = s_q.flags;

    // Identifier, flag and high capture word checks
    a_org_fixed: assert property (@(posedge clk_sys) disable iff (srst)
        psel && !penable && !pwrite && paddr == PWE_OFF_ORG_ID
        |=> prdata == PWE_ORG_ID_VAL)
        else $error("identifier read wrong");
    a_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
        acc && pwrite && paddr == PWE_OFF_FLAG_SET && pstrb[3] && pwdata[30] && !hw_flag_clr
        |=> ctrl_flags[30])
        else $error("set address did not set flag");
    a_flag_clr: assert property (@(posedge clk_sys) disable iff (srst)
        acc && pwrite && paddr == PWE_OFF_FLAG_CLR && pstrb[3] && pwdata[29]
        |=> !ctrl_flags[29])
        else $error("clear address did not clear flag");
    a_ro_bits: assert property (@(posedge clk_sys) disable iff (srst)
        (ctrl_flags & ~(PWE_FLAG_RSU | PWE_FLAG_RSC | PWE_FLAG_RC)) == PWE_FLAG_RST)
        else $error("read-only flag bits changed");
    a_zero_keep: assert property (@(posedge clk_sys) disable iff (srst)
        acc && pwrite && paddr == PWE_OFF_FLAG_SET && !hw_flag_clr
        |=> ctrl_flags == ($past(ctrl_flags) | (ctrl_flags & $past(wmask))))
        else $error("zero bits changed flags");
    a_hi_read: assert property (@(posedge clk_sys) disable iff (srst)
        psel && !penable && paddr == PWE_OFF_OFFS_HI ##1 acc
        |-> prdata == $past(offs_hi_q))
        else $error("high capture read wrong");
    a_no_wr_err: assert property (@(posedge clk_sys) disable iff (srst)
        acc && pwrite && paddr == PWE_OFF_OFFS_HI |-> pslverr)
        else $error("write to read-only word accepted");

    // Capture words and refusals
    a_ro_wr_err: assert property (@(posedge clk_sys) disable iff (srst)
        acc && pwrite && is_ro_word(paddr) |-> pslverr)
        else $error("identifier or capture write accepted");
    a_ro_wr_keep: assert property (@(posedge clk_sys) disable iff (srst)
        acc && pwrite && is_ro_word(paddr) && !fail_stb
        |=> $stable(offs_hi_q) && $stable(offs_lo_q))
        else $error("software write changed capture");
    a_lo_read: assert property (@(posedge clk_sys) disable iff (srst)
        psel && !penable && paddr == PWE_OFF_OFFS_LO ##1 acc
        |-> prdata == $past(offs_lo_q))
        else $error("low capture read wrong");
    a_read_ok: assert property (@(posedge clk_sys) disable iff (srst)
        acc && !pwrite && (is_ro_word(paddr) || is_flag_word(paddr)) |-> !pslverr)
        else $error("mapped read refused");
    // Read data stands from one setup to the next
    a_rd_stands: assert property (@(posedge clk_sys) disable iff (srst)
        !(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");

    // Flag word: update bit against link enable and hardware clear, then set, clear and readback
    a_link_guard: assert property (@(posedge clk_sys) disable iff (srst)
        set_wr && ctrl_flags[PWE_LINK_EN_BIT] && !ctrl_flags[PWE_BIB_BIT]
        |=> !ctrl_flags[PWE_BIB_BIT])
        else $error("update bit set while link enabled");
    a_hw_clear: assert property (@(posedge clk_sys) disable iff (srst)
        hw_flag_clr && !set_wr |=> !ctrl_flags[PWE_BIB_BIT])
        else $error("hardware clear ignored");
    a_set_wins: assert property (@(posedge clk_sys) disable iff (srst)
        set_wr && hw_flag_clr && wmask[PWE_BIB_BIT] && !ctrl_flags[PWE_LINK_EN_BIT]
        |=> ctrl_flags[PWE_BIB_BIT])
        else $error("hardware clear beat software set");
    a_flags_idle: assert property (@(posedge clk_sys) disable iff (srst)
        !(acc && pwrite) && !hw_flag_clr |=> $stable(ctrl_flags))
        else $error("flags moved without a cause");
    a_clr_all: assert property (@(posedge clk_sys) disable iff (srst)
        clr_wr |=> (ctrl_flags & $past(wmask)
                    & (PWE_FLAG_RSU | PWE_FLAG_RSC | PWE_FLAG_RC)) == PWE_ZERO)
        else $error("clear address left a flag set");
    a_clr_keep: assert property (@(posedge clk_sys) disable iff (srst)
        clr_wr && !hw_flag_clr
        |=> ((ctrl_flags ^ $past(ctrl_flags)) & ~$past(wmask)) == PWE_ZERO)
        else $error("clear address touched a zero bit");
    a_clr_no_set: assert property (@(posedge clk_sys) disable iff (srst)
        clr_wr |=> (ctrl_flags & ~$past(ctrl_flags)) == PWE_ZERO)
        else $error("clear address set a flag");
    a_set_takes: assert property (@(posedge clk_sys) disable iff (srst)
        set_wr
        |=> ($past(wmask) & PWE_FLAG_RSC & ~ctrl_flags) == PWE_ZERO)
        else $error("set address missed a flag");
    a_flag_read: assert property (@(posedge clk_sys) disable iff (srst)
        psel && !penable && is_flag_word(paddr) ##1 acc
        |-> prdata == $past(ctrl_flags))
        else $error("flag readback wrong");

    c_set_wr:   cover property (@(posedge clk_sys) set_wr);
    c_clr_wr:   cover property (@(posedge clk_sys) clr_wr);
    c_set_race: cover property (@(posedge clk_sys) set_wr && hw_flag_clr);
    c_fail_rd:  cover property (@(posedge clk_sys)
        fail_stb ##[1:20] acc && paddr == PWE_OFF_OFFS_HI);
endmodule

// ==== dv/pwe_node_model.sv ====
// Remote node model: reports failed posted writes
`timescale 1ns/10ps
module pwe_node_model (
    input  wire logic   clk_sys,
    output logic        fail_stb,
    output logic [9:0]  bus_num,
    output logic [5:0]  node_num,
    output logic [47:0] dest_offset
);
    initial begin
        fail_stb    = 1'b0;
        bus_num     = 10'h000;
        node_num    = 6'h00;
        dest_offset = 48'h0000_0000_0000;
    end
    // One-cycle failure report with its details
    task automatic send_fail(input logic [9:0] b, input logic [5:0] n, input logic [47:0] o);
        @(posedge clk_sys);
        fail_stb    <= 1'b1;
        bus_num     <= b;
        node_num    <= n;
        dest_offset <= o;
        @(posedge clk_sys);
        fail_stb    <= 1'b0;
        // Stale fields inverted so a late sample cannot pass
        bus_num     <= ~b;
        node_num    <= ~n;
        dest_offset <= ~o;
    endtask
endmodule

// ==== dv/pwe_regs_bench.sv ====
// Self-checking bench for the posted-write error register bank
`timescale 1ns/10ps
module pwe_regs_bench;
    import pwe_pkg::*;
    logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr, er;
    logic        hw_flag_clr, fstb;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, ctrl_flags, rd;
    logic [9:0]  fbus;
    logic [5:0]  fnode;
    logic [47:0] foffs;
    int          bad_count, n_compared, cycles;
    pwe_regs pwe_regs_i (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fail_stb(fstb), .fail_bus_num(fbus),
        .fail_node_num(fnode), .fail_dest_offset(foffs), .hw_flag_clr(hw_flag_clr),
        .ctrl_flags(ctrl_flags));
    pwe_node_model pwe_node_model_i (.clk_sys(clk_sys), .fail_stb(fstb), .bus_num(fbus),
        .node_num(fnode), .dest_offset(foffs));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Full APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic flag_op(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [31:0] exp);
        apb(1'b1, a, d, s);
        apb(1'b0, a ^ 8'h04, 32'h0000_0000, 4'hF);
        check("flags read", rd, exp);
        check("flags port", ctrl_flags, exp);
    endtask
    task automatic t_capture();
        pwe_node_model_i.send_fail(10'h2A5, 6'h1B, 48'hA5C3_1234_5678);
        apb(1'b0, PWE_OFF_OFFS_HI, 32'h0000_0000, 4'hF);
        check("offs hi", rd, 32'hA95B_A5C3);
        apb(1'b0, PWE_OFF_OFFS_LO, 32'h0000_0000, 4'hF);
        check("offs lo", rd, 32'h1234_5678);
        pwe_node_model_i.send_fail(10'h15A, 6'h24, 48'h5A3C_8765_4321);
        pwe_node_model_i.send_fail(10'h0C3, 6'h3F, 48'h0F0F_2468_ACE0);
        apb(1'b0, PWE_OFF_OFFS_HI, 32'h0000_0000, 4'hF);
        check("offs hi new", rd, 32'h30FF_0F0F);
        apb(1'b0, PWE_OFF_OFFS_LO, 32'h0000_0000, 4'hF);
        check("offs lo new", rd, 32'h2468_ACE0);
    endtask
    task automatic t_readonly();
        apb(1'b1, PWE_OFF_OFFS_HI, 32'hFFFF_FFFF, 4'hF);
        check("hi wr err", {31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b0, PWE_OFF_OFFS_HI, 32'h0000_0000, 4'hF);
        check("hi kept", rd, 32'h30FF_0F0F);
        apb(1'b1, PWE_OFF_ORG_ID, 32'h1234_5678, 4'hF);
        check("id wr err", {31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b0, PWE_OFF_ORG_ID, 32'h0000_0000, 4'hF);
        check("org id", rd, PWE_ORG_ID_VAL);
        apb(1'b0, 8'h10, 32'h0000_0000, 4'hF);
        check("unmapped data", rd, PWE_ZERO);
        check("unmapped err", {31'h0000_0000, er}, 32'h0000_0001);
    endtask
    task automatic t_flags();
        check("flags reset", ctrl_flags, PWE_FLAG_RST);
        flag_op(PWE_OFF_FLAG_SET, 32'h8000_0000, 4'hF, 32'h8080_0000);
        // Masked lanes must not set the upper-half flags
        flag_op(PWE_OFF_FLAG_SET, 32'h6007_0000, 4'h3, 32'h8080_0000);
        flag_op(PWE_OFF_FLAG_SET, 32'hFFFF_FFFF, 4'hF, 32'hE087_0000);
        flag_op(PWE_OFF_FLAG_CLR, 32'h8000_0000, 4'hF, 32'h6087_0000);
        flag_op(PWE_OFF_FLAG_SET, 32'h8000_0000, 4'hF, 32'h6087_0000);
        flag_op(PWE_OFF_FLAG_CLR, 32'h0002_0000, 4'hF, 32'h6085_0000);
        flag_op(PWE_OFF_FLAG_SET, 32'h8000_0000, 4'hF, 32'hE085_0000);
        @(posedge clk_sys);
        hw_flag_clr <= 1'b1;
        @(posedge clk_sys);
        hw_flag_clr <= 1'b0;
        @(posedge clk_sys);
        check("hw clear", ctrl_flags, 32'h6085_0000);
        flag_op(PWE_OFF_FLAG_CLR, 32'hFFFF_FFFF, 4'hF, PWE_FLAG_RST);
    endtask
    // Hardware clear pulse lands on the access edge of a software set
    task automatic t_set_race();
        fork
            apb(1'b1, PWE_OFF_FLAG_SET, 32'h8000_0000, 4'hF);
            begin
                repeat (2) @(posedge clk_sys);
                hw_flag_clr <= 1'b1;
                @(posedge clk_sys);
                hw_flag_clr <= 1'b0;
            end
        join
        @(posedge clk_sys);
        check("set beats hw clear", ctrl_flags, 32'h8080_0000);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        {srst, psel, penable, pwrite, hw_flag_clr} = 5'b10000;
        {paddr, pstrb, pwdata} = 44'h000_0000_0000;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        t_flags();
        t_set_race();
        t_capture();
        t_readonly();
        print_verdict();
    end
endmodule
